// file: core/msft_modem_flow.v
`timescale 1ns/1ps
`include "msft_map.vh"
// Contract
// - status visible when all three banks closed
// - bit7 is inverted CD, loopback control bit3
// - bit6 is inverted RI, loopback control bit2
// - bit5 is inverted DSR, loopback control bit0
// - bit4 is inverted CTS, loopback control bit1
// - bit3 sets on any CD change
// - bit2 sets only on RI low-to-high
// - bit1 sets on any DSR change
// - bit0 sets on any CTS change
// - any change flag plus enable raises interrupt
// - thresholds visible with enhanced, bank, not special (code gives the offset to the stop character when line control BF)
// - fill at or below resume level reasserts RTS
// - software mode sends resume at resume level
// - fill at or above halt level drops RTS
// - software mode sends stop at halt level
// - stop character visible when line control BF (code also hides it while the special bank is open)
// - upper modem control bits need enhanced mode
module msft_modem_flow #(
  parameter FILL_W = 7
) (
  input wire clock,
  input wire rst,
  input wire [2:0] regAddr,
  input wire [7:0] regWdata,
  input wire regWr,
  input wire regRd,
  output reg [7:0] regRdata,
  input wire cdPinN,
  input wire riPinN,
  input wire dsrPinN,
  input wire ctsPinN,
  input wire [FILL_W-1:0] rxFill,
  input wire modemIrqEn,
  output reg rtsPinN,
  output reg dtrPinN,
  output reg sendResume,
  output reg sendStop,
  output reg modemIrq
);
  reg [7:0] lineCtrl_r;
  reg [7:0] modemCtrl_r;
  reg [7:0] modemCtrl_nxt;
  reg [7:0] enhFeat_r;
  reg [7:0] specFunc_r;
  reg [7:0] flowThr_r;
  reg [7:0] stopChar_r;
  reg [1:0] flowMode_r;
  reg [3:0] lineLvlPrev_r;
  reg haltSent_r;
  wire cdSync;
  wire riSync;
  wire dsrSync;
  wire ctsSync;
  wire loopOn;
  wire [3:0] lineLvl;
  wire [3:0] deltaFlag;
  wire statusVis;
  wire thrVis;
  wire stopVis;
  wire statusRead;
  wire [FILL_W:0] resumeLvl;
  wire [FILL_W:0] haltLvl;
  wire [FILL_W:0] fillExt;
  wire atResume;
  wire atHalt;
  wire [7:0] statusByte;

  // Pins come from the remote device, so each passes two flops
  // Reset value 1 is the idle pin level, so no false change follows reset
  msft_sync #(.RESET_VAL(1'b1)) uSyncCd (
    .clock(clock),
    .rst(rst),
    .pinIn(cdPinN),
    .syncOut(cdSync)
  );
  msft_sync #(.RESET_VAL(1'b1)) uSyncRi (
    .clock(clock),
    .rst(rst),
    .pinIn(riPinN),
    .syncOut(riSync)
  );
  msft_sync #(.RESET_VAL(1'b1)) uSyncDsr (
    .clock(clock),
    .rst(rst),
    .pinIn(dsrPinN),
    .syncOut(dsrSync)
  );
  msft_sync #(.RESET_VAL(1'b1)) uSyncCts (
    .clock(clock),
    .rst(rst),
    .pinIn(ctsPinN),
    .syncOut(ctsSync)
  );

  // Loopback select; pins are ignored while it is set
  assign loopOn = modemCtrl_r[`MSFT_MDM_LOOP];

  // Status levels {CD,RI,DSR,CTS}; loopback takes them from modem control
  assign lineLvl[3] = loopOn ? modemCtrl_r[3] : ~cdSync;
  assign lineLvl[2] = loopOn ? modemCtrl_r[2] : ~riSync;
  assign lineLvl[1] = loopOn ? modemCtrl_r[0] : ~dsrSync;
  assign lineLvl[0] = loopOn ? modemCtrl_r[1] : ~ctsSync;

  // Bank decode for the shared offset
  assign statusVis = ~lineCtrl_r[`MSFT_LINE_BANK] & ~modemCtrl_r[`MSFT_MDM_BANK] & ~specFunc_r[`MSFT_SPF_BANK];
  assign thrVis = enhFeat_r[`MSFT_ENH_BIT] & modemCtrl_r[`MSFT_MDM_BANK] & ~specFunc_r[`MSFT_SPF_BANK];
  assign stopVis = (lineCtrl_r == `MSFT_LINE_ENH) & ~specFunc_r[`MSFT_SPF_BANK];
  // Only a read that really returns the status byte may clear its flags
  assign statusRead = regRd & (regAddr == `MSFT_OFF_STATUS) & statusVis & ~stopVis & ~thrVis;

  // Previous levels track the status inputs, seeded so reset sees no change
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      lineLvlPrev_r <= 4'h0;
    end else begin
      lineLvlPrev_r <= lineLvl;
    end
  end

  // Flag for RI is set when the RI# pin goes high, i.e. status level falls
  msft_delta #(.RISE_ONLY(1'b0)) uDeltaCd (
    .clock(clock),
    .rst(rst),
    .levelNow(lineLvl[3]),
    .levelPrev(lineLvlPrev_r[3]),
    .clearReq(statusRead),
    .flag_r(deltaFlag[3])
  );
  msft_delta #(.RISE_ONLY(1'b1)) uDeltaRi (
    .clock(clock),
    .rst(rst),
    .levelNow(~lineLvl[2]),
    .levelPrev(~lineLvlPrev_r[2]),
    .clearReq(statusRead),
    .flag_r(deltaFlag[2])
  );
  msft_delta #(.RISE_ONLY(1'b0)) uDeltaDsr (
    .clock(clock),
    .rst(rst),
    .levelNow(lineLvl[1]),
    .levelPrev(lineLvlPrev_r[1]),
    .clearReq(statusRead),
    .flag_r(deltaFlag[1])
  );
  msft_delta #(.RISE_ONLY(1'b0)) uDeltaCts (
    .clock(clock),
    .rst(rst),
    .levelNow(lineLvl[0]),
    .levelPrev(lineLvlPrev_r[0]),
    .clearReq(statusRead),
    .flag_r(deltaFlag[0])
  );

  // Levels in the high nibble, sticky change flags in the low nibble

  assign statusByte = {lineLvl, deltaFlag};

  // Protected modem control bits keep their value unless enhanced mode is on
  always @* begin
    modemCtrl_nxt = regWdata;
    if (!enhFeat_r[`MSFT_ENH_BIT]) begin
      modemCtrl_nxt[7:5] = modemCtrl_r[7:5];
      modemCtrl_nxt[3:2] = modemCtrl_r[3:2];
    end
  end

  // Register writes; the shared offset goes to whichever bank is open
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      lineCtrl_r <= `MSFT_RST_BYTE;
      modemCtrl_r <= `MSFT_RST_BYTE;
      enhFeat_r <= `MSFT_RST_BYTE;
      specFunc_r <= `MSFT_RST_BYTE;
      flowThr_r <= `MSFT_RST_BYTE;
      stopChar_r <= `MSFT_RST_BYTE;
      flowMode_r <= 2'h0;
    end else if (regWr) begin
      case (regAddr)
        `MSFT_OFF_LINECTL: begin
          lineCtrl_r <= regWdata;
        end
        `MSFT_OFF_MODEMCTL: begin
          modemCtrl_r <= modemCtrl_nxt;
        end
        `MSFT_OFF_ENHFEAT: begin
          enhFeat_r <= regWdata;
        end
        `MSFT_OFF_SPECFN: begin
          specFunc_r <= regWdata;
        end
        `MSFT_OFF_FLOW: begin
          flowMode_r <= regWdata[1:0];
        end
        // The status byte is read-only, so a write with it open is dropped
        `MSFT_OFF_THRESH: begin
          if (stopVis) begin
            stopChar_r <= regWdata;
          end else if (thrVis) begin
            flowThr_r <= regWdata;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Read data one cycle after the strobe; closed banks read zero
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      regRdata <= `MSFT_RST_BYTE;
    end else if (regRd) begin
      case (regAddr)
        `MSFT_OFF_LINECTL: begin
          regRdata <= lineCtrl_r;
        end
        `MSFT_OFF_MODEMCTL: begin
          regRdata <= modemCtrl_r;
        end
        `MSFT_OFF_ENHFEAT: begin
          regRdata <= enhFeat_r;
        end
        `MSFT_OFF_SPECFN: begin
          regRdata <= specFunc_r;
        end
        `MSFT_OFF_FLOW: begin
          regRdata <= {6'h00, flowMode_r};
        end
        // Priority matches the write path so a read shows what a write hits
        `MSFT_OFF_STATUS: begin
          if (stopVis) begin
            regRdata <= stopChar_r;
          end else if (thrVis) begin
            regRdata <= flowThr_r;
          end else if (statusVis) begin
            regRdata <= statusByte;
          end else begin
            regRdata <= 8'h00;
          end
        end
        default: regRdata <= 8'h00;
      endcase
    end else begin
      regRdata <= 8'h00;
    end
  end

  // Thresholds are the 4-bit fields times four; a resume level above the
  // halt level (against advice) makes RTS follow the halt compare first
  assign fillExt = {1'b0, rxFill};
  assign resumeLvl = {{(FILL_W-5){1'b0}}, flowThr_r[7:4], 2'b00};
  assign haltLvl = {{(FILL_W-5){1'b0}}, flowThr_r[3:0], 2'b00};
  assign atResume = (fillExt <= resumeLvl);
  assign atHalt = (fillExt >= haltLvl);

  // Auto RTS output; follows modem control bit 1 when automatic mode is off
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      rtsPinN <= 1'b1;
    end else if (!flowMode_r[`MSFT_FLOW_AUTORTS]) begin
      rtsPinN <= ~modemCtrl_r[1];
    end else if (atHalt) begin
      rtsPinN <= 1'b1;
    end else if (atResume) begin
      rtsPinN <= 1'b0;
    end
  end

  // Software flow: one stop pulse at halt, one resume pulse after, then armed for the next halt
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      haltSent_r <= 1'b0;
      sendStop <= 1'b0;
      sendResume <= 1'b0;
    end else begin
      sendStop <= 1'b0;
      sendResume <= 1'b0;
      if (!flowMode_r[`MSFT_FLOW_AUTOSW]) begin
        haltSent_r <= 1'b0;
      end else if (!haltSent_r && atHalt) begin
        haltSent_r <= 1'b1;
        sendStop <= 1'b1;
      end else if (haltSent_r && atResume && !atHalt) begin
        haltSent_r <= 1'b0;
        sendResume <= 1'b1;
      end
    end
  end

  // DTR follows modem control, interrupt from any change flag
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      dtrPinN <= 1'b1;
      modemIrq <= 1'b0;
    end else begin
      dtrPinN <= ~modemCtrl_r[0];
      modemIrq <= modemIrqEn & (|deltaFlag);
    end
  end
endmodule

// file: core/msft_map.vh
`ifndef MSFT_MAP_VH
`define MSFT_MAP_VH
// Register offsets (3-bit register address space)
`define MSFT_OFF_LINECTL 3'h3
`define MSFT_OFF_MODEMCTL 3'h4
`define MSFT_OFF_STATUS 3'h6
`define MSFT_OFF_THRESH 3'h6
`define MSFT_OFF_STOPCHR 3'h6
`define MSFT_OFF_ENHFEAT 3'h2
`define MSFT_OFF_SPECFN 3'h7
`define MSFT_OFF_FLOW 3'h5
// Bank select values and bits
`define MSFT_LINE_ENH 8'hBF
`define MSFT_LINE_BANK 7
`define MSFT_MDM_BANK 2
`define MSFT_MDM_LOOP 4
`define MSFT_SPF_BANK 2
`define MSFT_ENH_BIT 4
// Flow control mode bits in the flow mode register
`define MSFT_FLOW_AUTORTS 0
`define MSFT_FLOW_AUTOSW 1
// Reset values
`define MSFT_RST_BYTE 8'h00
// Threshold multiplier shift (times four)
`define MSFT_THR_SHIFT 2
`endif

// file: core/msft_sync.v
`timescale 1ns/1ps
// Two-stage synchroniser for one pin input
module msft_sync #(
  parameter RESET_VAL = 1'b1
) (
  input wire clock,
  input wire rst,
  input wire pinIn,
  output reg syncOut
);
  reg stage1_r;
  // First stage feeds only the second stage
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1_r <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1_r <= pinIn;
      syncOut <= stage1_r;
    end
  end
endmodule

// file: core/msft_delta.v
`timescale 1ns/1ps
// Sticky change flag for one modem line; set wins over read clear
module msft_delta #(
  parameter RISE_ONLY = 1'b0
) (
  input wire clock,
  input wire rst,
  input wire levelNow,
  input wire levelPrev,
  input wire clearReq,
  output reg flag_r
);
  wire hit;
  // Rising of the pin level only, or any change
  assign hit = RISE_ONLY ? (levelNow & ~levelPrev) : (levelNow ^ levelPrev);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      flag_r <= 1'b0;
    end else if (hit) begin
      flag_r <= 1'b1;
    end else if (clearReq) begin
      flag_r <= 1'b0;
    end
  end
endmodule

// file: bench/msft_modem_flow_chk.sv
`timescale 1ns/1ps
// Port-level checks on modem status, interrupt and flow pulses
module msft_modem_flow_chk (
  input wire clock,
  input wire rst,
  input wire regRd,
  input wire [7:0] regRdata,
  input wire cdPinN,
  input wire riPinN,
  input wire dsrPinN,
  input wire ctsPinN,
  input wire modemIrqEn,
  input wire rtsPinN,
  input wire sendResume,
  input wire sendStop,
  input wire modemIrq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Lines quiet with interrupt enabled, so any earlier line change has had time to reach the interrupt
  sequence s_quiet;
    (modemIrqEn && $stable({cdPinN, riPinN, dsrPinN, ctsPinN}))[*6];
  endsequence
  // Window after a change with no read that could clear the flag early
  sequence s_settle;
    (modemIrqEn && !regRd)[*4];
  endsequence
  a_change_raises_irq: assert property (($changed({cdPinN, dsrPinN, ctsPinN}) || $rose(riPinN)) ##1 s_settle
    |-> modemIrq) else $error("modem change gave no interrupt");
  a_ri_fall_quiet: assert property (s_quiet ##0 !modemIrq ##1 $fell(riPinN) ##1 s_quiet
    |-> !modemIrq) else $error("falling ring line raised interrupt");
  a_irq_off_disabled: assert property (!modemIrqEn |=> !modemIrq)
    else $error("interrupt while disabled");
  a_rd_data_idle: assert property (!regRd |=> regRdata == 8'h00)
    else $error("read data outside read cycle");
  a_reset_quiet: assert property ($past(rst) |-> !modemIrq && rtsPinN)
    else $error("outputs not idle after reset");
  a_stop_single: assert property (sendStop |=> !sendStop)
    else $error("stop request longer than one cycle");
  a_resume_single: assert property (sendResume |=> !sendResume)
    else $error("resume request longer than one cycle");
  a_halt_wins: assert property (sendStop |-> !sendResume)
    else $error("stop and resume together");
endmodule
bind msft_modem_flow msft_modem_flow_chk msft_modem_flow_chk_i (.clock(clock), .rst(rst), .regRd(regRd),
  .regRdata(regRdata), .cdPinN(cdPinN), .riPinN(riPinN), .dsrPinN(dsrPinN), .ctsPinN(ctsPinN),
  .modemIrqEn(modemIrqEn), .rtsPinN(rtsPinN), .sendResume(sendResume), .sendStop(sendStop), .modemIrq(modemIrq));

// file: bench/msft_remote.sv
`timescale 1ns/1ps
// Remote modem end: drives the four active-low status lines
module msft_remote (
  input wire clock,
  input wire [3:0] want,
  output reg cdPinN,
  output reg riPinN,
  output reg dsrPinN,
  output reg ctsPinN
);
  // Lines idle high, so the synchronisers see no change at reset release
  initial {cdPinN, riPinN, dsrPinN, ctsPinN} = 4'hF;
  // Lines step just after an edge, like a real driver clocked by us
  always @(posedge clock) begin
    {cdPinN, riPinN, dsrPinN, ctsPinN} <= want;
  end
endmodule

// file: bench/test_msft_modem_flow.sv
`timescale 1ns/1ps
module test_msft_modem_flow;
  reg clock = 1'b0;
  reg rst = 1'b1;
  reg [2:0] regAddr = 3'h0;
  reg [7:0] regWdata = 8'h00;
  reg regWr = 1'b0;
  reg regRd = 1'b0;
  reg [6:0] rxFill = 7'h00;
  reg modemIrqEn = 1'b0;
  reg [3:0] want = 4'hF;
  reg [7:0] d;
  wire [7:0] regRdata;
  wire cdPinN, riPinN, dsrPinN, ctsPinN, rtsPinN, dtrPinN, sendResume, sendStop, modemIrq;
  integer error_cnt = 0, n_compared = 0, cycles = 0, stops = 0, resumes = 0;
  msft_modem_flow msft_modem_flow_i (.clock(clock), .rst(rst), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .cdPinN(cdPinN), .riPinN(riPinN), .dsrPinN(dsrPinN),
    .ctsPinN(ctsPinN), .rxFill(rxFill), .modemIrqEn(modemIrqEn), .rtsPinN(rtsPinN), .dtrPinN(dtrPinN),
    .sendResume(sendResume), .sendStop(sendStop), .modemIrq(modemIrq));
  msft_remote msft_remote_i (.clock(clock), .want(want), .cdPinN(cdPinN), .riPinN(riPinN),
    .dsrPinN(dsrPinN), .ctsPinN(ctsPinN));
  initial forever #25 clock = ~clock;
  // Pulse tally and hang guard; the run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    stops <= stops + sendStop;
    resumes <= resumes + sendResume;
    if (cycles == 4000) begin
      error_cnt = error_cnt + 1;
      stop_test;
    end
  end
  task stop_test;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input [8*8-1:0] what, input [7:0] exp, input [7:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("BAD %0s exp %h got %h", what, exp, got);
    end
  endtask
  task waitc(input integer n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task wr(input [2:0] a, input [7:0] v);
    @(posedge clock);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clock);
    regWr <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe, so sample just past that edge
  task rd(input [2:0] a);
    @(posedge clock);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clock);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask
  task pins(input [3:0] v);
    @(posedge clock);
    want <= v;
    waitc(8);
  endtask
  task fill(input [6:0] v);
    @(posedge clock);
    rxFill <= v;
    waitc(3);
  endtask
  // Main sequence: modem lines, loopback, thresholds, then bank selection
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    rd(3'h6); chk("status", 8'h00, d);
    rd(3'h0); chk("unmap", 8'h00, d);
    chk("dtr", 8'h01, {7'h00, dtrPinN});
    @(posedge clock) modemIrqEn <= 1'b1;
    pins(4'hE); chk("irq", 8'h01, {7'h00, modemIrq});
    rd(3'h6); chk("status", 8'h11, d);
    rd(3'h6); chk("status", 8'h10, d);
    waitc(2); chk("irq", 8'h00, {7'h00, modemIrq});
    pins(4'h4); rd(3'h6); chk("status", 8'hBA, d);
    pins(4'h0); chk("irq", 8'h00, {7'h00, modemIrq});
    rd(3'h6); chk("status", 8'hF0, d);
    pins(4'h4); rd(3'h6); chk("status", 8'hB4, d);
    @(posedge clock) modemIrqEn <= 1'b0;
    pins(4'hF); chk("irq", 8'h00, {7'h00, modemIrq});
    @(posedge clock) modemIrqEn <= 1'b1;
    waitc(2); chk("irq", 8'h01, {7'h00, modemIrq});
    rd(3'h6); chk("status", 8'h0B, d);
    wr(3'h4, 8'h1F); waitc(3); chk("dtr", 8'h00, {7'h00, dtrPinN});
    rd(3'h6); chk("loop", 8'h30, d & 8'hF0);
    wr(3'h2, 8'h10); wr(3'h4, 8'h1B); waitc(3); rd(3'h6); chk("loop", 8'hB0, d & 8'hF0);
    wr(3'h4, 8'h04); wr(3'h6, 8'h24); rd(3'h6); chk("thresh", 8'h24, d);
    wr(3'h5, 8'h01);
    fill(7'h00); chk("rts", 8'h00, {7'h00, rtsPinN});
    fill(7'h10); chk("rts", 8'h01, {7'h00, rtsPinN});
    fill(7'h09); chk("rts", 8'h01, {7'h00, rtsPinN});
    fill(7'h08); chk("rts", 8'h00, {7'h00, rtsPinN});
    wr(3'h5, 8'h02);
    fill(7'h10); fill(7'h14); chk("stops", 8'h01, stops[7:0]);
    fill(7'h08); chk("resumes", 8'h01, resumes[7:0]);
    wr(3'h3, 8'hBF); rd(3'h6); chk("stopchr", 8'h00, d);
    wr(3'h6, 8'h5A); rd(3'h6); chk("stopchr", 8'h5A, d);
    wr(3'h3, 8'h03); rd(3'h6); chk("thresh", 8'h24, d);
    wr(3'h7, 8'h04); rd(3'h6); chk("closed", 8'h00, d);
    wr(3'h7, 8'h00); wr(3'h4, 8'h00); wr(3'h3, 8'h80); rd(3'h6); chk("closed", 8'h00, d);
    stop_test;
  end
endmodule
